// ---- rtl/board_irq_router_cfg.svh ----
`ifndef BOARD_IRQ_ROUTER_CFG_SVH
`define BOARD_IRQ_ROUTER_CFG_SVH

// Register offsets in function 0 configuration space
`define ROUTE_0_OFFSET   8'h70
`define ROUTE_1_OFFSET   8'h71
// Route register reset value and field positions
`define ROUTE_RESET      8'h80
`define ROUTE_DISABLE    7
`define ROUTE_SHARE      6
`define ROUTE_TIMER_OUT  5
`define ROUTE_SEL_HI     3
`define ROUTE_SEL_LO     0
// Writable bits; bit 4 always reads zero
`define ROUTE_WMASK_LATE 8'hEF
`define ROUTE_WMASK_EARLY 8'hCF
// Request line count and selector width
`define IRQ_LINES        16
`define SEL_WIDTH        4

`endif

// ---- rtl/board_irq_router_pkg.sv ----
package board_irq_router_pkg;
`include "board_irq_router_cfg.svh"
   typedef logic [7:0]              route_t;
   typedef logic [`IRQ_LINES-1:0]   irq_vec_t;
   typedef logic [`SEL_WIDTH-1:0]   sel_t;
endpackage

// ---- rtl/board_irq_router.sv ----
`timescale 1ns/1ns
`include "board_irq_router_cfg.svh"
module board_irq_router #(
   parameter bit LATER_VARIANT = 1'b1
) (
   input  wire logic                          clock,
   input  wire logic                          srst,
   input  wire logic [7:0]                    cfg_addr,
   input  wire logic                          cfg_wr,
   input  wire board_irq_router_pkg::route_t  cfg_wdata,
   input  wire logic                          cfg_rd,
   output board_irq_router_pkg::route_t       cfg_rdata,
   input  wire logic                          shared_board_timer_int_pin_in,
   output logic                               shared_board_timer_int_pin_out,
   output logic                               shared_board_timer_int_pin_oe,
   input  wire logic                          board_device_int_in,
   input  wire logic                          timer_irq,
   input  wire board_irq_router_pkg::irq_vec_t isa_irq_in,
   input  wire board_irq_router_pkg::irq_vec_t pci_line_req,
   output board_irq_router_pkg::irq_vec_t     irq_req_out,
   output logic                               ide_int_set
);
   import board_irq_router_pkg::*;

   localparam int NUM_INPUTS = LATER_VARIANT ? 1 : 2;

   // Selector to one-hot request line, zero for reserved codes
   function automatic irq_vec_t decode_line(input sel_t code);
      irq_vec_t v;
      v = '0;
      case (code)
         4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
         4'h9, 4'hA, 4'hB, 4'hC,
         4'hE, 4'hF: v[code] = 1'b1;
         default:    v = '0;
      endcase
      return v;
   endfunction

   route_t   route [2];
   route_t   next_rdata;
   irq_vec_t board_drive [2];
   irq_vec_t isa_mask    [2];
   irq_vec_t drive_all;
   irq_vec_t mask_all;
   logic     timer_mode;
   logic     board_in [2];

   assign timer_mode = LATER_VARIANT && route[0][`ROUTE_TIMER_OUT];
   // Shared pin is no input while it carries the timer
   assign board_in[0] = shared_board_timer_int_pin_in && !timer_mode;
   assign board_in[1] = board_device_int_in && !LATER_VARIANT;

   // Route register writes, one per existing input
   generate
      for (genvar i = 0; i < 2; i++) begin : g_route
         always_ff @(posedge clock) begin
            if (srst) begin
               route[i] <= `ROUTE_RESET;
            end else if (cfg_wr && i < NUM_INPUTS &&
                         cfg_addr == `ROUTE_0_OFFSET + 8'(i)) begin
               route[i] <= cfg_wdata & (LATER_VARIANT && i == 0 ?
                           `ROUTE_WMASK_LATE : `ROUTE_WMASK_EARLY);
            end
         end
         // Per-input steering and ISA masking
         always_comb begin
            irq_vec_t hit;
            hit = '0;
            if (i < NUM_INPUTS && !route[i][`ROUTE_DISABLE]) begin
               hit = decode_line(
                  route[i][`ROUTE_SEL_HI:`ROUTE_SEL_LO]);
            end
            board_drive[i] = hit & {`IRQ_LINES{board_in[i]}};
            isa_mask[i] = hit & ({`IRQ_LINES{!route[i][`ROUTE_SHARE]}}
                                 | pci_line_req);
         end
      end
   endgenerate

   assign drive_all = board_drive[0] | board_drive[1];
   assign mask_all  = isa_mask[0] | isa_mask[1];

   // Read data mux, unmapped offsets read zero
   always_comb begin
      next_rdata = '0;
      if (cfg_addr == `ROUTE_0_OFFSET) begin
         next_rdata = route[0];
      end else if (cfg_addr == `ROUTE_1_OFFSET && !LATER_VARIANT) begin
         next_rdata = route[1];
      end
   end

   // Registered read answer
   always_ff @(posedge clock) begin
      if (srst) begin
         cfg_rdata <= '0;
      end else if (cfg_rd) begin
         cfg_rdata <= next_rdata;
      end
   end

   // Request lines to the interrupt controller
   always_ff @(posedge clock) begin
      if (srst) begin
         irq_req_out <= '0;
      end else begin
         irq_req_out <= (isa_irq_in & ~mask_all) | drive_all;
      end
   end

   // Shared pin direction and timer output
   always_ff @(posedge clock) begin
      if (srst) begin
         shared_board_timer_int_pin_oe  <= 1'b0;
         shared_board_timer_int_pin_out <= 1'b0;
      end else begin
         shared_board_timer_int_pin_oe  <= timer_mode;
         shared_board_timer_int_pin_out <= timer_mode && timer_irq;
      end
   end

   // IDE status flag source select
   always_ff @(posedge clock) begin
      if (srst) begin
         ide_int_set <= 1'b0;
      end else if (timer_mode) begin
         ide_int_set <= isa_irq_in[15];
      end else begin
         ide_int_set <= shared_board_timer_int_pin_in;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   AST_RESET_VALUE: assert property (
      $past(srst) |-> route[0] == `ROUTE_RESET)
      else $error("route 0 not at reset value");
   AST_DISABLED_PASS: assert property (
      $past(!srst && route[0][`ROUTE_DISABLE] && route[1][`ROUTE_DISABLE])
      |-> irq_req_out == $past(isa_irq_in))
      else $error("disabled route altered request lines");
   AST_ROUTE_LINE3: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'h3
            && shared_board_timer_int_pin_in) |-> irq_req_out[3])
      else $error("board input not routed to line 3");
   AST_ROUTE_LINE14: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'hE
            && shared_board_timer_int_pin_in) |-> irq_req_out[14])
      else $error("code 1110 not routed to line 14");
   AST_UNSHARED_MASK: assert property (
      $past(route[0][7:6] == 2'b00 && route[0][3:0] == 4'h5
            && route[1][7] && !board_in[0] && isa_irq_in[5])
      |-> !irq_req_out[5])
      else $error("unshared route left ISA line 5 open");
   AST_PCI_MASK: assert property (
      $past(route[0][7] == 1'b0 && route[0][3:0] == 4'h5
            && pci_line_req[5] && route[1][7] && !board_in[0]
            && isa_irq_in[5]) |-> !irq_req_out[5])
      else $error("PCI shared line left ISA open");
   AST_RESERVED_CODE: assert property (
      $past(route[0][7] == 1'b0 && route[0][3:0] == 4'hD
            && route[1][7]) |-> irq_req_out == $past(isa_irq_in))
      else $error("reserved code changed request lines");
   AST_TIMER_PIN: assert property (
      $past(timer_mode) |-> shared_board_timer_int_pin_oe
      && shared_board_timer_int_pin_out == $past(timer_irq))
      else $error("shared pin not driving timer");
   AST_IDE_SOURCE: assert property (
      ##1 ide_int_set == ($past(timer_mode) ? $past(isa_irq_in[15])
                          : $past(shared_board_timer_int_pin_in)))
      else $error("IDE flag source wrong");
   AST_RESET_PIN_INPUT: assert property (
      $past(srst) |-> ##1 !shared_board_timer_int_pin_oe)
      else $error("shared pin driven after reset");
   AST_ROUTE1_ABSENT: assert property (
      $past(cfg_rd && cfg_addr == `ROUTE_1_OFFSET && LATER_VARIANT)
      |-> cfg_rdata == 8'h00)
      else $error("absent route register read nonzero");


   // Selector codes at the ends of each mapped group
   AST_ROUTE_LINE7: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'h7
            && shared_board_timer_int_pin_in) |-> irq_req_out[7])
      else $error("code 0111 not routed to line 7");

   AST_ROUTE_LINE9: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'h9
            && shared_board_timer_int_pin_in) |-> irq_req_out[9])
      else $error("code 1001 not routed to line 9");

   AST_ROUTE_LINE12: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'hC
            && shared_board_timer_int_pin_in) |-> irq_req_out[12])
      else $error("code 1100 not routed to line 12");

   AST_ROUTE_LINE15: assert property (
      $past(!timer_mode && route[0][7] == 1'b0 && route[0][3:0] == 4'hF
            && shared_board_timer_int_pin_in) |-> irq_req_out[15])
      else $error("code 1111 not routed to line 15");

   // Sharing keeps the ISA source visible
   AST_SHARED_OPEN: assert property (
      $past(route[0][7:6] == 2'b01 && route[0][3:0] == 4'h5
            && !pci_line_req[5] && isa_irq_in[5]) |-> irq_req_out[5])
      else $error("shared route blocked ISA line 5");

   // Low reserved codes and code 1000 leave lines untouched
   AST_RESERVED_LOW: assert property (
      $past(route[0][7] == 1'b0 && (route[0][3:0] < 4'h3
            || route[0][3:0] == 4'h8) && route[1][7])
      |-> irq_req_out == $past(isa_irq_in))
      else $error("reserved low code changed request lines");

   // Pin stays an input outside timer mode
   AST_PIN_INPUT_MODE: assert property (
      $past(!timer_mode) |-> !shared_board_timer_int_pin_oe
      && !shared_board_timer_int_pin_out)
      else $error("shared pin driven outside timer mode");

   // Timer mode cuts the board input off the request lines
   AST_TIMER_NO_BOARD: assert property (
      $past(timer_mode && route[0][3:0] == 4'h3 && !isa_irq_in[3]
            && route[1][7]) |-> !irq_req_out[3])
      else $error("timer pin level reached request line");

   // Read answer holds between reads
   AST_RDATA_HOLD: assert property (
      !$past(cfg_rd) |-> $stable(cfg_rdata))
      else $error("read data changed without a read");

   AST_READ_ROUTE0: assert property (
      $past(cfg_rd && cfg_addr == `ROUTE_0_OFFSET)
      |-> cfg_rdata == $past(route[0]))
      else $error("route 0 read back wrong");

   // Reserved bit 4 never stored
   AST_BIT4_ZERO: assert property (
      !route[0][4] && !route[1][4])
      else $error("reserved bit 4 stored");

   // One input reaches at most one request line
   AST_ONE_TARGET: assert property (
      $past(route[1][7] && isa_irq_in == '0) |-> $onehot0(irq_req_out))
      else $error("board input reached several lines");

   // Outputs come out of reset cleared
   AST_RESET_OUTPUTS: assert property (
      $past(srst) |-> irq_req_out == '0 && !ide_int_set
      && cfg_rdata == '0)
      else $error("outputs not cleared by reset");

   // Scenario covers
   COV_RESERVED: cover property (route[0][7] == 1'b0
                                 && route[0][3:0] == 4'hD);
   COV_ROUTED: cover property (board_drive[0] != '0);
   COV_SHARED: cover property (route[0][7:6] == 2'b01 && isa_irq_in != 0);
   COV_TIMER: cover property (timer_mode ##1 shared_board_timer_int_pin_oe);
   COV_PCI: cover property (pci_line_req != 0 && isa_mask[0] != '0);
endmodule // board_irq_router

// ---- verif/board_periph_model.sv ----
`timescale 1ns/1ns
// Board peripheral holding an active high level interrupt
module board_periph_model (
   input  wire logic clock,
   input  wire logic raise,
   output logic      int_level
);
   // Level follows the request, never pulsed
   always_ff @(posedge clock) begin
      int_level <= raise;
   end
endmodule // board_periph_model

// ---- verif/tb_board_irq_router.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_board_irq_router;
   import board_irq_router_pkg::*;
   typedef struct {int kind; logic [15:0] exp;} note_t;
   logic       clock = 0, srst = 1, cfg_wr = 0, cfg_rd = 0, look = 0;
   logic [7:0] cfg_addr = 8'h00;
   route_t     cfg_wdata = 8'h00, cfg_rdata;
   logic       pin_in, pin_out, pin_oe, dev_lvl, ide_set;
   logic       raise = 0, bdi = 0, tmr = 0;
   irq_vec_t   isa = 16'h0000, pci = 16'h0000, irq_out;
   logic [15:0] pins;
   note_t      q[$];
   note_t      nt;
   int         n_errors = 0, tests_run = 0;
   // Clock and shared pin level
   always #25 clock = ~clock;
   assign pin_in = pin_oe ? pin_out : dev_lvl;
   assign pins = {13'h0000, ide_set, pin_oe, pin_out};
   board_periph_model dev (.clock(clock), .raise(raise), .int_level(dev_lvl));
   board_irq_router uut (.clock(clock), .srst(srst), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd),
      .cfg_rdata(cfg_rdata), .shared_board_timer_int_pin_in(pin_in),
      .shared_board_timer_int_pin_out(pin_out),
      .shared_board_timer_int_pin_oe(pin_oe), .board_device_int_in(bdi),
      .timer_irq(tmr), .isa_irq_in(isa), .pci_line_req(pci),
      .irq_req_out(irq_out), .ide_int_set(ide_set));
   // Bus and note helpers
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic expect_at(int k, logic [15:0] e);
      q.push_back('{k, e});
      look = 1;
      cyc(1);
      look = 0;
   endtask
   task automatic wr(logic [7:0] a, route_t d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1;
      cyc(1);
      cfg_wr = 0;
      cyc(1);
   endtask
   task automatic rd(logic [7:0] a, route_t e);
      cfg_addr = a;
      cfg_rd = 1;
      cyc(1);
      cfg_rd = 0;
      expect_at(0, {8'h00, e});
   endtask
   // One routing case with random neighbours
   task automatic route_case(logic [3:0] code, logic dis);
      route_t      r;
      logic [15:0] e;
      r = route_t'($urandom);
      r[7] = dis;
      r[5] = 1'b0;
      r[3:0] = code;
      isa = irq_vec_t'($urandom);
      pci = irq_vec_t'($urandom);
      r[6] = r[6] & ~pci[code];
      raise = 1'($urandom);
      tmr = 1'($urandom);
      bdi = 1'($urandom);
      wr(8'h70, r);
      cyc(1);
      e = isa;
      if (!dis && !(code < 3 || code == 8 || code == 13))
         e[code] = raise | (r[6] & isa[code]);
      expect_at(1, e);
      expect_at(2, {13'h0000, raise, 2'b00});
      rd(8'h70, r & 8'hEF);
   endtask
   // Closing report
   task automatic results;
      $display("Checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Monitor takes the oldest note when a result is due
   always @(posedge clock) if (look) begin
      nt = q.pop_front();
      case (nt.kind)
         0: `CHK("cfg_rdata", nt.exp, {8'h00, cfg_rdata})
         1: `CHK("irq_req_out", nt.exp, irq_out)
         default: `CHK("ide_pin", nt.exp, pins)
      endcase
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      results();
   end
   // Main sequence
   initial begin
      void'($urandom(92));
      cyc(6);
      srst = 0;
      rd(8'h70, 8'h80);
      rd(8'h71, 8'h00);
      wr(8'h72, 8'h03);
      wr(8'h71, 8'h03);
      rd(8'h70, 8'h80);
      rd(8'h71, 8'h00);
      for (int i = 0; i < 48; i++)
         route_case(i[3:0], i >= 16 ? 1'($urandom) : 1'b0);
      isa = irq_vec_t'($urandom);
      tmr = 1'b1;
      raise = 1'b1;
      wr(8'h70, 8'hB5);
      cyc(1);
      expect_at(1, isa);
      expect_at(2, {13'h0000, isa[15], 2'b11});
      tmr = 1'b0;
      isa[15] = ~isa[15];
      cyc(2);
      expect_at(2, {13'h0000, isa[15], 2'b10});
      rd(8'h70, 8'hA5);
      results();
   end
endmodule // tb_board_irq_router
